// [rtl/rlg_field_reg.sv]
// One 16-bit configuration register with byte-lane writes and a writable-bit mask
`timescale 1ns/10ps
module rlg_field_reg import rlg_pkg::*; #(
  parameter logic [15:0] WMASK = 16'hffff,
  parameter logic [15:0] RST_VAL = 16'h0000
) (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic wr_i,
  input wire logic [1:0] sel_i,
  input wire logic [15:0] wdat_i,
  output logic [15:0] q_o
);

  // ---------------------------------------------------------------------------
  // Storage
  // ---------------------------------------------------------------------------
  logic [15:0] lane_mask;
  logic [15:0] q_q;

  // Only enabled lanes and writable bits change; the rest keep their value
  assign lane_mask = WMASK & {{8{sel_i[1]}}, {8{sel_i[0]}}};

  // Register update
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      q_q <= RST_VAL;
    end else if (wr_i) begin
      q_q <= (q_q & ~lane_mask) | (wdat_i & lane_mask);
    end
  end

  assign q_o = q_q;

endmodule // rlg_field_reg

// [rtl/rlg_pkg.sv]
// Package: constants, offsets and carrier types of the receive link/group config bank
package rlg_pkg;

  // ---------------------------------------------------------------------------
  // Sizes
  // ---------------------------------------------------------------------------
  localparam int NUM_LINKS = 16;
  localparam int NUM_GROUPS = 8;
  localparam int NUM_PAIRS = 8;
  localparam int RING_ADDR_W = 5;
  localparam int GROUP_W = 3;
  localparam int LINK_W = 4;

  // ---------------------------------------------------------------------------
  // Register indices (byte address = 4 * index)
  // ---------------------------------------------------------------------------
  localparam logic [9:0] RING_IDX_BASE = 10'h1c0;
  localparam logic [9:0] PAIR_IDX_BASE = 10'h201;
  localparam logic [9:0] REF_IDX_BASE = 10'h209;

  // ---------------------------------------------------------------------------
  // Field positions
  // ---------------------------------------------------------------------------
  localparam int RING_CELL_SEL_BIT = 11;
  localparam int RING_CELL_ADDR_LSB = 6;
  localparam int RING_TDM_SEL_BIT = 5;
  localparam int RING_TDM_ADDR_LSB = 0;
  localparam int PAIR_HI_LSB = 8;
  localparam int PAIR_GROUP_LSB = 0;
  localparam int PAIR_EN_BIT = 4;
  localparam int REF_LINK_LSB = 0;
  localparam int REF_AUTO_BIT = 4;
  localparam int REF_CUR_LSB = 5;

  // ---------------------------------------------------------------------------
  // Reset values and writable bits
  // ---------------------------------------------------------------------------
  localparam logic [15:0] RING_RST = 16'h0000;
  localparam logic [15:0] PAIR_RST = 16'h0000;
  localparam logic [15:0] REF_RST = 16'h0000;
  localparam logic [15:0] RING_WMASK = 16'h0fff;
  localparam logic [15:0] PAIR_WMASK = 16'h1fff;
  localparam logic [15:0] REF_WMASK = 16'h001f;

  // ---------------------------------------------------------------------------
  // Carrier types
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic cyc;
    logic stb;
    logic we;
    logic [3:0] sel;
    logic [11:0] adr;
    logic [31:0] dat;
  } rlg_wb_req_s;

  typedef struct packed {
    logic cell_ring_sel;
    logic [RING_ADDR_W-1:0] cell_ring_addr;
    logic tdm_ring_sel;
    logic [RING_ADDR_W-1:0] tdm_ring_addr;
    logic recomb_en;
    logic [GROUP_W-1:0] group;
  } rlg_link_cfg_s;

endpackage

// [rtl/rlg_ref_sel.sv]
// Reference link chooser for one group: programmed number or automatic pick
`timescale 1ns/10ps
module rlg_ref_sel import rlg_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input wire logic auto_i,
  input wire logic [LINK_W-1:0] man_link_i,
  input wire logic [NUM_LINKS-1:0] cand_i,
  output logic [LINK_W-1:0] ref_o
);

  // ---------------------------------------------------------------------------
  // Selection
  // ---------------------------------------------------------------------------
  logic [LINK_W-1:0] ref_q;
  logic [LINK_W-1:0] low_idx;
  logic [NUM_LINKS-1:0] cand_q;

  // Lowest eligible link
  always_comb begin
    low_idx = '0;
    for (int k = NUM_LINKS - 1; k >= 0; k--) begin
      if (cand_i[k]) begin
        low_idx = LINK_W'(k);
      end
    end
  end

  // Manual: follow program; auto: keep a still-eligible link, else lowest eligible
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ref_q <= '0;
    end else if (!auto_i) begin
      ref_q <= man_link_i;
    end else if (!cand_i[ref_q] && (cand_i != '0)) begin
      ref_q <= low_idx;
    end
  end

  // Copy of eligibility for checking only
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      cand_q <= '0;
    end else begin
      cand_q <= cand_i;
    end
  end

  assign ref_o = ref_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  AST_REF_MANUAL: assert property (@(posedge clk_i) disable iff (rst_i)
    !auto_i |=> ref_o == $past(man_link_i))
    else $error("Manual reference link not taken");
  AST_REF_AUTO_ELIG: assert property (@(posedge clk_i) disable iff (rst_i)
    (auto_i && cand_i != '0) |=> cand_q[ref_o])
    else $error("Automatic reference link not eligible");
  AST_REF_AUTO_HOLD: assert property (@(posedge clk_i) disable iff (rst_i)
    (auto_i && (cand_i == '0 || cand_i[ref_o])) |=> $stable(ref_o))
    else $error("Automatic reference link changed without cause");

endmodule // rlg_ref_sel

// [rtl/rlg_rx_cfg.sv]
// Receive link ring routing, group assignment and reference link config bank
//
// Function
// - Cell-side ring select connects ring to link group
// - Per-link five-bit cell-side ring address
// - TDM-side ring select connects ring to receiver
// - Per-link five-bit TDM-side ring address
// - Sixteen ring routing registers, reset zero
// - Eight pair registers: link N low, N+8 high
// - Recombiner enable bit per link
// - Three-bit group code per link
// - Reserved pair bits written zero, upper read zero
// - Eight reference control registers, one per group
// - Auto bit makes device pick reference link
// - Otherwise programmed link number is reference
//
// The Wishbone interface to the registers was left to the implementer.
`timescale 1ns/10ps
module rlg_rx_cfg import rlg_pkg::*; (
  input wire logic clk_i,
  input wire logic rst_i,
  input rlg_wb_req_s wb_req_i,
  output logic wb_ack_o,
  output logic [31:0] wb_dat_o,
  input wire logic [NUM_LINKS-1:0] link_ok_i,
  output rlg_link_cfg_s [NUM_LINKS-1:0] link_cfg_o,
  output logic [NUM_GROUPS-1:0][LINK_W-1:0] ref_link_o,
  output logic [NUM_GROUPS-1:0] ref_auto_o
);

  // ---------------------------------------------------------------------------
  // Bus slave: decode
  // ---------------------------------------------------------------------------
  logic ack_q;
  logic [31:0] rdat_q;
  logic [31:0] rd_d;
  logic req_go;
  logic wr_go;
  logic [9:0] idx;
  logic [9:0] pair_ofs;
  logic [9:0] ref_ofs;
  logic ring_hit;
  logic pair_hit;
  logic ref_hit;
  logic [3:0] ring_n;
  logic [2:0] pair_n;
  logic [2:0] ref_n;
  logic [1:0] lane;

  // A new request is taken once per access; ack_q blocks a second take
  assign req_go = wb_req_i.cyc & wb_req_i.stb & ~ack_q;
  assign wr_go = req_go & wb_req_i.we;
  assign idx = wb_req_i.adr[11:2];
  assign pair_ofs = idx - PAIR_IDX_BASE;
  assign ref_ofs = idx - REF_IDX_BASE;
  assign lane = wb_req_i.sel[1:0];

  // Address decode into the three register groups
  always_comb begin
    ring_hit = 1'b0;
    pair_hit = 1'b0;
    ref_hit = 1'b0;
    ring_n = idx[3:0];
    pair_n = pair_ofs[2:0];
    ref_n = ref_ofs[2:0];
    if (idx[9:4] == RING_IDX_BASE[9:4]) begin
      ring_hit = 1'b1;
    end else if (idx >= PAIR_IDX_BASE && pair_ofs < 10'(NUM_PAIRS)) begin
      pair_hit = 1'b1;
    end else if (idx >= REF_IDX_BASE && ref_ofs < 10'(NUM_GROUPS)) begin
      ref_hit = 1'b1;
    end
  end

  // ---------------------------------------------------------------------------
  // Register storage
  // ---------------------------------------------------------------------------
  logic [15:0] ring_q [NUM_LINKS];
  logic [15:0] pair_q [NUM_PAIRS];
  logic [15:0] ref_q [NUM_GROUPS];
  logic [NUM_LINKS-1:0] ring_wr;
  logic [NUM_PAIRS-1:0] pair_wr;
  logic [NUM_GROUPS-1:0] ref_wr;

  // Ring routing registers, one per receive link
  for (genvar i = 0; i < NUM_LINKS; i++) begin : g_ring
    assign ring_wr[i] = wr_go & ring_hit & (ring_n == 4'(i));
    rlg_field_reg #(
      .WMASK(RING_WMASK),
      .RST_VAL(RING_RST)
    ) u_reg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(ring_wr[i]),
      .sel_i(lane),
      .wdat_i(wb_req_i.dat[15:0]),
      .q_o(ring_q[i])
    );
  end

  // Pair registers; reserved bits 11, 7:5 and 3 store what is written
  for (genvar i = 0; i < NUM_PAIRS; i++) begin : g_pair
    assign pair_wr[i] = wr_go & pair_hit & (pair_n == 3'(i));
    rlg_field_reg #(
      .WMASK(PAIR_WMASK),
      .RST_VAL(PAIR_RST)
    ) u_reg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(pair_wr[i]),
      .sel_i(lane),
      .wdat_i(wb_req_i.dat[15:0]),
      .q_o(pair_q[i])
    );
  end

  // Reference control registers, one per group
  for (genvar i = 0; i < NUM_GROUPS; i++) begin : g_refreg
    assign ref_wr[i] = wr_go & ref_hit & (ref_n == 3'(i));
    rlg_field_reg #(
      .WMASK(REF_WMASK),
      .RST_VAL(REF_RST)
    ) u_reg (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .wr_i(ref_wr[i]),
      .sel_i(lane),
      .wdat_i(wb_req_i.dat[15:0]),
      .q_o(ref_q[i])
    );
  end

  // ---------------------------------------------------------------------------
  // Per-link configuration outputs
  // ---------------------------------------------------------------------------
  // Link n takes the low half of pair n, link n+8 the high half
  for (genvar n = 0; n < NUM_LINKS; n++) begin : g_link
    localparam int P = n % NUM_PAIRS;
    localparam int H = (n >= NUM_PAIRS) ? PAIR_HI_LSB : 0;
    assign link_cfg_o[n].cell_ring_sel = ring_q[n][RING_CELL_SEL_BIT];
    assign link_cfg_o[n].cell_ring_addr = ring_q[n][RING_CELL_ADDR_LSB +: RING_ADDR_W];
    assign link_cfg_o[n].tdm_ring_sel = ring_q[n][RING_TDM_SEL_BIT];
    assign link_cfg_o[n].tdm_ring_addr = ring_q[n][RING_TDM_ADDR_LSB +: RING_ADDR_W];
    assign link_cfg_o[n].recomb_en = pair_q[P][H + PAIR_EN_BIT];
    assign link_cfg_o[n].group = pair_q[P][H + PAIR_GROUP_LSB +: GROUP_W];
  end

  // ---------------------------------------------------------------------------
  // Reference link selection
  // ---------------------------------------------------------------------------
  logic [NUM_LINKS-1:0] cand [NUM_GROUPS];

  // A link may serve as reference when usable, enabled and in the group
  for (genvar g = 0; g < NUM_GROUPS; g++) begin : g_grp
    for (genvar n = 0; n < NUM_LINKS; n++) begin : g_cand
      assign cand[g][n] = link_ok_i[n] & link_cfg_o[n].recomb_en &
                          (link_cfg_o[n].group == 3'(g));
    end
    assign ref_auto_o[g] = ref_q[g][REF_AUTO_BIT];
    rlg_ref_sel u_sel (
      .clk_i(clk_i),
      .rst_i(rst_i),
      .auto_i(ref_q[g][REF_AUTO_BIT]),
      .man_link_i(ref_q[g][REF_LINK_LSB +: LINK_W]),
      .cand_i(cand[g]),
      .ref_o(ref_link_o[g])
    );
  end

  // ---------------------------------------------------------------------------
  // Bus slave: read data and acknowledge
  // ---------------------------------------------------------------------------
  // Read mux; unused and unmapped bits read zero except reserved pair bits 11, 7:5 and 3, middle reference field shows
  // the link currently in use
  always_comb begin
    rd_d = 32'h0000_0000;
    if (ring_hit) begin
      rd_d[15:0] = ring_q[ring_n];
    end else if (pair_hit) begin
      rd_d[15:0] = pair_q[pair_n];
    end else if (ref_hit) begin
      rd_d[15:0] = ref_q[ref_n];
      rd_d[REF_CUR_LSB +: LINK_W] = ref_link_o[ref_n];
    end
  end

  // Acknowledge one cycle after the request, then drop for one cycle
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      ack_q <= 1'b0;
    end else begin
      ack_q <= req_go;
    end
  end

  // Read data register, loaded with the request
  always_ff @(posedge clk_i) begin
    if (rst_i) begin
      rdat_q <= 32'h0000_0000;
    end else if (req_go) begin
      rdat_q <= rd_d;
    end
  end

  assign wb_ack_o = ack_q;
  assign wb_dat_o = rdat_q;

  // ---------------------------------------------------------------------------
  // Checks
  // ---------------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (rst_i);

  AST_CELL_RING_SEL: assert property (
    (wr_go && idx == RING_IDX_BASE && lane[1])
    |=> link_cfg_o[0].cell_ring_sel == $past(wb_req_i.dat[RING_CELL_SEL_BIT]))
    else $error("Cell-side ring select not applied");

  AST_CELL_RING_ADDR: assert property (
    (wr_go && idx == RING_IDX_BASE + 10'h00f && lane == 2'b11)
    |=> link_cfg_o[15].cell_ring_addr ==
        $past(wb_req_i.dat[RING_CELL_ADDR_LSB +: RING_ADDR_W]))
    else $error("Cell-side ring address not applied");

  AST_TDM_RING_SEL: assert property (
    (wr_go && idx == RING_IDX_BASE + 10'h00f && lane[0])
    |=> link_cfg_o[15].tdm_ring_sel == $past(wb_req_i.dat[RING_TDM_SEL_BIT]))
    else $error("TDM-side ring select not applied");

  AST_TDM_RING_ADDR: assert property (
    (wr_go && idx == RING_IDX_BASE + 10'h00f && lane[0])
    |=> link_cfg_o[15].tdm_ring_addr ==
        $past(wb_req_i.dat[RING_TDM_ADDR_LSB +: RING_ADDR_W]))
    else $error("TDM-side ring address not applied");

  AST_RING_READ: assert property (
    (req_go && !wb_req_i.we && ring_hit)
    |=> wb_ack_o && wb_dat_o[31:12] == 20'h00000 ##1 !wb_ack_o)
    else $error("Ring register read answer wrong");

  AST_PAIR_GROUP: assert property (
    (wr_go && idx == PAIR_IDX_BASE && lane == 2'b11)
    |=> link_cfg_o[0].group == $past(wb_req_i.dat[2:0]) &&
        link_cfg_o[8].group == $past(wb_req_i.dat[10:8]))
    else $error("Pair group codes not split correctly");

  AST_RECOMB_EN: assert property (
    (wr_go && idx == PAIR_IDX_BASE + 10'h007 && lane[1])
    |=> link_cfg_o[15].recomb_en == $past(wb_req_i.dat[12]))
    else $error("Recombiner enable of high link not applied");

  AST_PAIR_UPPER_ZERO: assert property (
    (req_go && !wb_req_i.we && pair_hit)
    |=> wb_ack_o && wb_dat_o[31:13] == 19'h00000)
    else $error("Unused recombiner bits read nonzero");

  AST_REF_READ: assert property (
    (req_go && !wb_req_i.we && ref_hit)
    |=> wb_ack_o && wb_dat_o[31:9] == 23'h000000 &&
        wb_dat_o[REF_AUTO_BIT] == ref_auto_o[$past(ref_n)])
    else $error("Reference register read answer wrong");

  AST_CELL_SEL_LINK7: assert property (
    (wr_go && idx == RING_IDX_BASE + 10'h007 && lane[1])
    |=> link_cfg_o[7].cell_ring_sel == $past(wb_req_i.dat[RING_CELL_SEL_BIT]))
    else $error("Cell-side ring select of link 7 not applied");

  AST_TDM_SEL_LINK7: assert property (
    (wr_go && idx == RING_IDX_BASE + 10'h007 && lane[0])
    |=> link_cfg_o[7].tdm_ring_sel == $past(wb_req_i.dat[RING_TDM_SEL_BIT]))
    else $error("TDM-side ring select of link 7 not applied");

  AST_RECOMB_EN_LOW: assert property (
    (wr_go && idx == PAIR_IDX_BASE && lane[0])
    |=> link_cfg_o[0].recomb_en == $past(wb_req_i.dat[PAIR_EN_BIT]))
    else $error("Recombiner enable of low link not applied");

  AST_GROUP_HIGH: assert property (
    (wr_go && idx == PAIR_IDX_BASE + 10'h007 && lane[1])
    |=> link_cfg_o[15].group == $past(wb_req_i.dat[PAIR_HI_LSB +: GROUP_W]))
    else $error("Group code of high link not applied");

  AST_GROUP_LOW7: assert property (
    (wr_go && idx == PAIR_IDX_BASE + 10'h007 && lane[0])
    |=> link_cfg_o[7].group == $past(wb_req_i.dat[PAIR_GROUP_LSB +: GROUP_W]))
    else $error("Group code of low link not applied");

  AST_LOW_LANE_ONLY: assert property (
    (wr_go && idx == PAIR_IDX_BASE && lane == 2'b01)
    |=> link_cfg_o[8] == $past(link_cfg_o[8]) &&
        link_cfg_o[0].group == $past(wb_req_i.dat[2:0]))
    else $error("Low byte lane write disturbed the high link");

  AST_REF_AUTO_FLAG: assert property (
    (wr_go && idx == REF_IDX_BASE && lane[0])
    |=> ref_auto_o[0] == $past(wb_req_i.dat[REF_AUTO_BIT]))
    else $error("Automatic selection flag not applied");

  AST_REF_MAN_LINK: assert property (
    (wr_go && idx == REF_IDX_BASE + 10'h007 && lane[0] && !wb_req_i.dat[REF_AUTO_BIT])
    |-> ##2 ref_link_o[7] == $past(wb_req_i.dat[REF_LINK_LSB +: LINK_W], 2))
    else $error("Programmed reference link not in use");

  // ---------------------------------------------------------------------------
  // Checks: bus handshake
  // ---------------------------------------------------------------------------
  AST_ACK_ANSWER: assert property (
    req_go |=> wb_ack_o)
    else $error("Request not answered in one cycle");

  AST_ACK_PULSE: assert property (
    wb_ack_o |=> !wb_ack_o)
    else $error("Acknowledge held longer than one cycle");

  AST_ACK_IDLE: assert property (
    !(wb_req_i.cyc && wb_req_i.stb) |=> !wb_ack_o)
    else $error("Acknowledge without a request");

  AST_RDATA_HOLD: assert property (
    !req_go |=> $stable(wb_dat_o))
    else $error("Read data changed without a request");

  AST_UNMAPPED_READ: assert property (
    (req_go && !wb_req_i.we && !ring_hit && !pair_hit && !ref_hit)
    |=> wb_dat_o == 32'h0000_0000)
    else $error("Unmapped read returned nonzero data");

  AST_UNMAPPED_WRITE: assert property (
    (wr_go && !ring_hit && !pair_hit && !ref_hit)
    |=> $stable(link_cfg_o) && $stable(ref_auto_o))
    else $error("Unmapped write changed a register");

  AST_REF_CUR_FIELD: assert property (
    (req_go && !wb_req_i.we && ref_hit)
    |=> wb_dat_o[REF_CUR_LSB +: LINK_W] == $past(ref_link_o[ref_n]))
    else $error("Reference read does not show the link in use");

  // ---------------------------------------------------------------------------
  // Checks: values after reset
  // ---------------------------------------------------------------------------
  AST_CFG_RESET: assert property (
    $fell(rst_i) |-> link_cfg_o == '0 && !wb_ack_o && wb_dat_o == 32'h0000_0000)
    else $error("Link configuration not zero after reset");

  AST_REF_RESET: assert property (
    $fell(rst_i) |-> ref_auto_o == '0 && ref_link_o == '0)
    else $error("Reference control not zero after reset");

endmodule // rlg_rx_cfg

// [verif/rlg_rx_cfg_tb.sv]
// Self-checking bench for the receive link and group configuration bank
`timescale 1ns/10ps
module rlg_rx_cfg_tb import rlg_pkg::*; ();
  // ---------------------------------------------------------------------------
  // Signals and table of ordinary cases
  // ---------------------------------------------------------------------------
  typedef struct packed {
    logic [9:0] idx;
    logic [15:0] wd;
    logic [31:0] mask;
    logic [31:0] exp;
    logic [4:0] lk;
    rlg_link_cfg_s cfg;
  } rlg_tb_row_s;
  localparam int NROWS = 11;
  // Write value, read mask, expected read, watched link (31 = none), expected link config
  localparam rlg_tb_row_s ROWS [NROWS] = '{
    '{10'h1c0, 16'hffff, 32'hffffffff, 32'h00000fff, 5'd0, 16'hfff0},
    '{10'h1cf, 16'h0a95, 32'hffffffff, 32'h00000a95, 5'd15, 16'ha950},
    '{10'h1c7, 16'h0820, 32'hffffffff, 32'h00000820, 5'd7, 16'h8200},
    '{10'h201, 16'h1717, 32'hffffffff, 32'h00001717, 5'd0, 16'hffff},
    '{10'h208, 16'h1305, 32'hffffffff, 32'h00001305, 5'd15, 16'ha95b},
    '{10'h208, 16'h1305, 32'hffffffff, 32'h00001305, 5'd7, 16'h8205},
    '{10'h201, 16'h1717, 32'hffffffff, 32'h00001717, 5'd8, 16'h000f},
    '{10'h209, 16'hffff, 32'hfffffe1f, 32'h0000001f, 5'd31, 16'h0000},
    '{10'h210, 16'h002a, 32'hfffffe1f, 32'h0000000a, 5'd31, 16'h0000},
    '{10'h1d0, 16'hffff, 32'hffffffff, 32'h00000000, 5'd31, 16'h0000},
    '{10'h200, 16'hffff, 32'hffffffff, 32'h00000000, 5'd31, 16'h0000}
  };
  logic clk_i;
  logic rst_i;
  rlg_wb_req_s req;
  logic wb_ack_o;
  logic [31:0] wb_dat_o;
  logic [NUM_LINKS-1:0] link_ok_i;
  rlg_link_cfg_s [NUM_LINKS-1:0] link_cfg_o;
  logic [NUM_GROUPS-1:0][LINK_W-1:0] ref_link_o;
  logic [NUM_GROUPS-1:0] ref_auto_o;
  logic [31:0] rdv;
  int error_cnt = 0;
  int n_compared = 0;
  int cyc_cnt = 0;

  rlg_rx_cfg uut (
    .clk_i(clk_i),
    .rst_i(rst_i),
    .wb_req_i(req),
    .wb_ack_o(wb_ack_o),
    .wb_dat_o(wb_dat_o),
    .link_ok_i(link_ok_i),
    .link_cfg_o(link_cfg_o),
    .ref_link_o(ref_link_o),
    .ref_auto_o(ref_auto_o)
  );

  // ---------------------------------------------------------------------------
  // Clock, hang guard and shared tasks
  // ---------------------------------------------------------------------------
  // 50 ns period
  always #25 clk_i = ~clk_i;

  // Cuts the run short if a wait never ends
  always @(posedge clk_i) begin
    cyc_cnt <= cyc_cnt + 1;
    if (cyc_cnt == 3000) begin
      error_cnt++;
      tally_and_finish();
    end
  end

  // Classic single cycle: hold the request until ack is seen at a rising edge, release there
  task automatic wb_cycle(input logic w, input logic [9:0] idx, input logic [15:0] d,
                          input logic [1:0] s, output logic [31:0] rd);
    @(posedge clk_i);
    req.cyc <= 1'b1;
    req.stb <= 1'b1;
    req.we <= w;
    req.sel <= {2'b00, s};
    req.adr <= {idx, 2'b00};
    req.dat <= {16'h0000, d};
    do begin
      @(posedge clk_i);
    end while (wb_ack_o !== 1'b1);
    rd = wb_dat_o;
    req.cyc <= 1'b0;
    req.stb <= 1'b0;
  endtask

  task automatic chk_word(input string nm, input logic [31:0] e, input logic [31:0] g);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  task automatic chk_cfg(input string nm, input rlg_link_cfg_s e, input rlg_link_cfg_s g);
    n_compared++;
    if (g !== e) begin
      $display("CHECK FAILED %s expected %h seen %h", nm, e, g);
      error_cnt++;
    end
  endtask

  // Lets the chooser settle for two edges, looks between edges, returns on a rising edge
  task automatic chk_ref(input int g, input logic [3:0] e);
    repeat (2) @(posedge clk_i);
    @(negedge clk_i);
    n_compared++;
    if (ref_link_o[g] !== e) begin
      $display("CHECK FAILED reference link expected %h seen %h", e, ref_link_o[g]);
      error_cnt++;
    end
    @(posedge clk_i);
  endtask

  task automatic tally_and_finish();
    if (error_cnt == 0 && n_compared > 0) begin
      $display("All tests passed");
    end else begin
      $display("Some tests failed");
    end
    $finish;
  endtask

  // ---------------------------------------------------------------------------
  // Main sequence
  // ---------------------------------------------------------------------------
  initial begin
    clk_i = 1'b0;
    rst_i = 1'b1;
    req = '0;
    link_ok_i = '1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    // Table: write, read back, watch the link outputs
    for (int i = 0; i < NROWS; i++) begin
      wb_cycle(1'b1, ROWS[i].idx, ROWS[i].wd, 2'b11, rdv);
      wb_cycle(1'b0, ROWS[i].idx, 16'h0000, 2'b11, rdv);
      chk_word("read data", ROWS[i].exp, rdv & ROWS[i].mask);
      if (ROWS[i].lk != 5'd31) begin
        chk_cfg("link config", ROWS[i].cfg, link_cfg_o[ROWS[i].lk[3:0]]);
      end
    end
    chk_ref(7, 4'ha);
    // Low byte lane only
    wb_cycle(1'b1, 10'h201, 16'h0012, 2'b01, rdv);
    wb_cycle(1'b0, 10'h201, 16'h0000, 2'b11, rdv);
    chk_word("read data", 32'h00001712, rdv);
    chk_cfg("link config", 16'hfffa, link_cfg_o[0]);
    // Automatic pick within group 3: links 4 and 12
    wb_cycle(1'b1, 10'h205, 16'h1313, 2'b11, rdv);
    wb_cycle(1'b1, 10'h20c, 16'h0010, 2'b11, rdv);
    chk_ref(3, 4'h4);
    link_ok_i <= 16'hffef;
    chk_ref(3, 4'hc);
    link_ok_i <= 16'h0000;
    chk_ref(3, 4'hc);
    link_ok_i <= 16'hefff;
    chk_ref(3, 4'h4);
    link_ok_i <= 16'hffff;
    wb_cycle(1'b1, 10'h205, 16'h1303, 2'b11, rdv);
    chk_ref(3, 4'hc);
    chk_word("auto flags", 32'h00000009, {24'h000000, ref_auto_o});
    // Second reset in mid-run: everything back to zero
    @(posedge clk_i);
    rst_i <= 1'b1;
    repeat (16) @(posedge clk_i);
    rst_i <= 1'b0;
    @(negedge clk_i);
    chk_word("reference links", 32'h00000000, ref_link_o);
    chk_word("auto flags", 32'h00000000, {24'h000000, ref_auto_o});
    for (int i = 0; i < NUM_LINKS; i++) begin
      chk_cfg("link config", 16'h0000, link_cfg_o[i]);
    end
    for (int i = 0; i < 32; i++) begin
      wb_cycle(1'b0, (i < 16) ? 10'h1c0 + 10'(i) : 10'h1f1 + 10'(i), 16'h0000, 2'b11, rdv);
      chk_word("reset value", 32'h00000000, rdv & ((i < 24) ? 32'hffffffff : 32'hfffffe1f));
    end
    tally_and_finish();
  end
endmodule // rlg_rx_cfg_tb
